// >>> src/hscsp_pkg.sv
// package of constants for the hub strap capture and status pins block
package hscsp_pkg;
    localparam int NUM_PORTS = 2;
    localparam int ADDR_WIDTH = 7;
    // target address strap bit positions, and the fixed bit 3 with its value
    localparam int ADDR_BIT1_POS = 1;
    localparam int ADDR_BIT2_POS = 2;
    localparam int ADDR_BIT3_POS = 3;
    localparam logic ADDR_BIT3_VALUE = 1'b1;
    // low address bits not set by straps; value is arbitrary
    localparam logic [6:0] ADDR_BASE = 7'h40;
    // strap reset values of the latches
    localparam logic BUS_MODE_RESET = 1'b1;
    localparam logic POLARITY_RESET = 1'b0;
    localparam logic GANG_RESET = 1'b0;
    localparam logic SWITCH_RESET = 1'b1;
    localparam logic TEST_RESET = 1'b0;
    // strap encodings
    localparam logic BUS_MODE_SMBUS = 1'b0;
    localparam logic POLARITY_ACTIVE_LOW = 1'b1;
    localparam logic GANG_GANGED = 1'b1;
    localparam logic SWITCH_SUPPORTED = 1'b0;
    // pin direction: enable low drives the pin
    localparam logic OE_DRIVE = 1'b0;
    localparam logic OE_RELEASE = 1'b1;
    typedef enum logic [2:0] {
        HSCSP_RESET = 3'h1,
        HSCSP_SAMPLE = 3'h2,
        HSCSP_RUN = 3'h4
    } hscsp_phase_type;
endpackage

// >>> src/hscsp_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
module hscsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage1_reg <= '0;
            syncOut <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule

// >>> src/hub_strap_capture_status_pins.sv
// strap capture at reset release and link status outputs on the shared pins
//
// What this block does
// - at reset release, bus-mode strap 0 selects SMBus target, 1 selects I2C master.
// - after reset, bus-mode pin drives port 2 SuperSpeed status.
// - at reset release, polarity strap 0 means power outputs active high, 1 low.
// - after reset, polarity pin drives port 1 SuperSpeed status.
// - gang strap 0 picks per-port power control, 1 ganged, when switching enabled.
// - power-switching strap 0 enables downstream power switching, 1 disables it.
// - with switching, each port powered through its power and charging outputs.
// - in SMBus mode address bit 2 is gang strap, bit 1 switching strap.
// - target address bit 3 is 1 in both bus modes once straps are valid; it reads 0 before that.
// - after reset, gang pin drives upstream high-speed status.
// - after reset, switching pin drives upstream SuperSpeed status.
// - test input high at reset enters factory test mode.
// - in ganged mode an overcurrent is reported as a hub event.
// - serial clock acts as SMBus target clock for 0, I2C clock for 1.
`timescale 1ns/1ns
module hub_strap_capture_status_pins
    import hscsp_pkg::*;
#(
    parameter int NUM_DOWN = hscsp_pkg::NUM_PORTS
) (
    input wire logic clk,
    input wire logic sys_rst,
    // shared strap/status pins: input, output, output enable (low drives)
    input wire logic busModePinIn,
    output logic busModePinOut,
    output logic busModePinOe,
    input wire logic polarityPinIn,
    output logic polarityPinOut,
    output logic polarityPinOe,
    input wire logic gangPinIn,
    output logic gangPinOut,
    output logic gangPinOe,
    input wire logic switchPinIn,
    output logic switchPinOut,
    output logic switchPinOe,
    input wire logic testPinIn,
    // link state from the hub core, same clock
    input wire logic [NUM_DOWN-1:0] portSuperSpeed,
    input wire logic upstreamHighSpeed,
    input wire logic upstreamSuperSpeed,
    // power requests from the hub core and overcurrent pins
    input wire logic [NUM_DOWN-1:0] portPowerRequest,
    input wire logic [NUM_DOWN-1:0] portChargeRequest,
    input wire logic [NUM_DOWN-1:0] portOvercurrentInN,
    // serial clock pin seen by the serial engines
    input wire logic serialClockIn,
    // outputs
    output logic [NUM_DOWN-1:0] portPowerControlOut,
    output logic [NUM_DOWN-1:0] chargingEnableOut,
    output logic [NUM_DOWN-1:0] portOvercurrentEvent,
    output logic hubOvercurrentEvent,
    output logic smbusTargetMode,
    output logic i2cMasterMode,
    output logic smbusTargetClock,
    output logic i2cMemoryClock,
    output logic [hscsp_pkg::ADDR_WIDTH-1:0] targetAddress,
    output logic gangedMode,
    output logic powerSwitchingOn,
    output logic factoryTestMode,
    output logic strapsValid
);
    import hscsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronise pin inputs
    localparam int SYNC_W = 6 + NUM_DOWN;
    logic [SYNC_W-1:0] syncIn;
    logic busModeSync, polaritySync, gangSync, switchSync, testSync, serialClockSync;
    logic [NUM_DOWN-1:0] overcurrentSyncN;

    hscsp_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({portOvercurrentInN, serialClockIn, testPinIn,
                  switchPinIn, gangPinIn, polarityPinIn, busModePinIn}),
        .syncOut(syncIn)
    );
    assign busModeSync = syncIn[0];
    assign polaritySync = syncIn[1];
    assign gangSync = syncIn[2];
    assign switchSync = syncIn[3];
    assign testSync = syncIn[4];
    assign serialClockSync = syncIn[5];
    assign overcurrentSyncN = syncIn[SYNC_W-1 -: NUM_DOWN];

    ////////////////////////////////////////////////////////////////////////
    // phase: reset, then sample once the synchronisers carry real pin values
    hscsp_phase_type phase_reg, phase_next;
    logic [1:0] settle_reg;
    logic settleDone;
    assign settleDone = (settle_reg == 2'h2);

    always_comb begin
        phase_next = phase_reg;
        unique case (phase_reg)
            HSCSP_RESET: begin
                if (settleDone) begin
                    phase_next = HSCSP_SAMPLE;
                end
            end
            HSCSP_SAMPLE: phase_next = HSCSP_RUN;
            HSCSP_RUN: phase_next = HSCSP_RUN;
            default: phase_next = HSCSP_RESET;
        endcase
    end

    // pins stay released while the straps settle through the synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_reg <= HSCSP_RESET;
            settle_reg <= 2'h0;
        end else begin
            phase_reg <= phase_next;
            if (!settleDone) begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap latches, loaded once in the sample phase
    logic busMode_reg, polarity_reg, gang_reg, switch_reg, test_reg;
    logic doSample;
    assign doSample = (phase_reg == HSCSP_SAMPLE);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busMode_reg <= BUS_MODE_RESET;
            polarity_reg <= POLARITY_RESET;
            gang_reg <= GANG_RESET;
            switch_reg <= SWITCH_RESET;
            test_reg <= TEST_RESET;
        end else if (doSample) begin
            busMode_reg <= busModeSync;
            polarity_reg <= polaritySync;
            gang_reg <= gangSync;
            switch_reg <= switchSync;
            test_reg <= testSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decoded modes
    logic isSmbus, isGanged, isSwitching, running;
    logic [ADDR_WIDTH-1:0] addrNext;
    assign isSmbus = (busMode_reg == BUS_MODE_SMBUS);
    assign isSwitching = (switch_reg == SWITCH_SUPPORTED);
    assign isGanged = isSwitching && (gang_reg == GANG_GANGED);
    assign running = (phase_reg == HSCSP_RUN);

    // address straps only mean anything in SMBus mode; otherwise use the base; bit 3 is set in both modes
    always_comb begin
        addrNext = ADDR_BASE;
        if (isSmbus) begin
            addrNext[ADDR_BIT2_POS] = gang_reg;
            addrNext[ADDR_BIT1_POS] = switch_reg;
        end
        addrNext[ADDR_BIT3_POS] = ADDR_BIT3_VALUE;
    end

    // power: ganged ports follow any request; polarity flips the pin level
    logic anyPower, anyCharge, anyOvercurrent;
    logic [NUM_DOWN-1:0] powerLevel, chargeLevel, overcurrent;
    assign anyPower = |portPowerRequest;
    assign anyCharge = |portChargeRequest;
    assign overcurrent = ~overcurrentSyncN;
    assign anyOvercurrent = |overcurrent;
    assign powerLevel = !isSwitching ? '0 : (isGanged ? {NUM_DOWN{anyPower}} : portPowerRequest);
    assign chargeLevel = !isSwitching ? '0 : (isGanged ? {NUM_DOWN{anyCharge}} : portChargeRequest);

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busModePinOut <= 1'b0;
            polarityPinOut <= 1'b0;
            gangPinOut <= 1'b0;
            switchPinOut <= 1'b0;
            busModePinOe <= OE_RELEASE;
            polarityPinOe <= OE_RELEASE;
            gangPinOe <= OE_RELEASE;
            switchPinOe <= OE_RELEASE;
            portPowerControlOut <= '0;
            chargingEnableOut <= '0;
            portOvercurrentEvent <= '0;
            hubOvercurrentEvent <= 1'b0;
            smbusTargetMode <= 1'b0;
            i2cMasterMode <= 1'b0;
            smbusTargetClock <= 1'b0;
            i2cMemoryClock <= 1'b0;
            targetAddress <= '0;
            gangedMode <= 1'b0;
            powerSwitchingOn <= 1'b0;
            factoryTestMode <= 1'b0;
            strapsValid <= 1'b0;
        end else if (running) begin
            busModePinOut <= portSuperSpeed[1];
            polarityPinOut <= portSuperSpeed[0];
            gangPinOut <= upstreamHighSpeed;
            switchPinOut <= upstreamSuperSpeed;
            busModePinOe <= OE_DRIVE;
            polarityPinOe <= OE_DRIVE;
            gangPinOe <= OE_DRIVE;
            switchPinOe <= OE_DRIVE;
            // off level is the inactive polarity, so an unpowered port stays off
            portPowerControlOut <= (polarity_reg == POLARITY_ACTIVE_LOW) ? ~powerLevel : powerLevel;
            chargingEnableOut <= chargeLevel;
            portOvercurrentEvent <= isGanged ? '0 : overcurrent;
            hubOvercurrentEvent <= isGanged && anyOvercurrent;
            smbusTargetMode <= isSmbus;
            i2cMasterMode <= !isSmbus;
            smbusTargetClock <= isSmbus ? serialClockSync : 1'b0;
            i2cMemoryClock <= isSmbus ? 1'b0 : serialClockSync;
            targetAddress <= addrNext;
            gangedMode <= isGanged;
            powerSwitchingOn <= isSwitching;
            factoryTestMode <= test_reg;
            strapsValid <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_bit3;
        @(posedge clk) disable iff (sys_rst) strapsValid |-> targetAddress[ADDR_BIT3_POS] == 1'b1;
    endproperty
    a_bit3: assert property (p_bit3) else $error("address bit 3 not one");

    property p_mode;
        @(posedge clk) disable iff (sys_rst)
            strapsValid |-> smbusTargetMode == (busMode_reg == BUS_MODE_SMBUS) && i2cMasterMode != smbusTargetMode;
    endproperty
    a_mode: assert property (p_mode) else $error("bus mode decode wrong");

    property p_ss2;
        @(posedge clk) disable iff (sys_rst)
            running |=> busModePinOut == $past(portSuperSpeed[1]) && busModePinOe == OE_DRIVE;
    endproperty
    a_ss2: assert property (p_ss2) else $error("port 2 status pin wrong");

    property p_ss1;
        @(posedge clk) disable iff (sys_rst) running |=> polarityPinOut == $past(portSuperSpeed[0]);
    endproperty
    a_ss1: assert property (p_ss1) else $error("port 1 status pin wrong");

    property p_hs;
        @(posedge clk) disable iff (sys_rst)
            running |=> gangPinOut == $past(upstreamHighSpeed) && switchPinOut == $past(upstreamSuperSpeed);
    endproperty
    a_hs: assert property (p_hs) else $error("upstream status pins wrong");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
            running && $past(running) |-> $stable(busMode_reg) && $stable(gang_reg) && $stable(switch_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("strap latch changed after sampling");

    property p_addr;
        @(posedge clk) disable iff (sys_rst)
            strapsValid && smbusTargetMode |-> targetAddress[ADDR_BIT2_POS] == gang_reg
                && targetAddress[ADDR_BIT1_POS] == switch_reg;
    endproperty
    a_addr: assert property (p_addr) else $error("address strap bits wrong");

    property p_gang_oc;
        @(posedge clk) disable iff (sys_rst) strapsValid && gangedMode |-> portOvercurrentEvent == '0;
    endproperty
    a_gang_oc: assert property (p_gang_oc) else $error("port event in ganged mode");

    property p_nosw;
        @(posedge clk) disable iff (sys_rst)
            strapsValid && !powerSwitchingOn |-> chargingEnableOut == '0 && !gangedMode;
    endproperty
    a_nosw: assert property (p_nosw) else $error("power driven without switching");

    property p_sample;
        @(posedge clk) disable iff (sys_rst)
            doSample |=> busMode_reg == $past(busModeSync) && test_reg == $past(testSync);
    endproperty
    a_sample: assert property (p_sample) else $error("strap not captured");
endmodule

// >>> test/hscsp_board.sv
// board side model: strap resistors and status indicators on the shared pins
`timescale 1ns/1ns
module hscsp_board (
    input wire logic [3:0] strapLevel,
    input wire logic [3:0] pinDrive,
    input wire logic [3:0] pinOeN,
    output logic [3:0] pinLevel
);
    import hscsp_pkg::*;
    // a released pin settles at its strap resistor level; the weak resistor loses to a driver
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinLevel[i] = (pinOeN[i] == OE_DRIVE) ? pinDrive[i] : strapLevel[i];
        end
    end
endmodule

// >>> test/testbench.sv
// self-checking bench for strap capture and shared status pins
`timescale 1ns/1ns
module testbench;
    import hscsp_pkg::*;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic [3:0] strapVal = 4'h0; // bit0 bus mode, bit1 polarity, bit2 gang, bit3 switching
    logic testPin = 1'b0;
    wire [3:0] pinOut, pinOe;
    logic [3:0] pinLevel;
    logic [1:0] portSs = 2'h0, pwrReq = 2'h0, chgReq = 2'h0, ocN = 2'h3;
    logic upHs = 1'b0, upSs = 1'b0, serClk = 1'b0;
    logic [1:0] pwrOut, chgOut, ocEvt, expPwr;
    logic hubOc, smbMode, i2cMode, smbClk, i2cClk, ganged, swOn, testMode, valid;
    logic bm, pol, gang, sw;
    logic [4:0] cfg;
    logic [6:0] addr, expAddr;
    logic [4:0] cfgTab [5] = '{5'h00, 5'h17, 5'h0e, 5'h09, 5'h04};
    int fails = 0, nCompared = 0, cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // clock, watchdog and the parties on the pins
    always #25 clk = ~clk;
    // generous ceiling: the full sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            close_out();
        end
    end
    hscsp_board u_board (.strapLevel(strapVal), .pinDrive(pinOut), .pinOeN(pinOe), .pinLevel(pinLevel));
    hub_strap_capture_status_pins u_dut (
        .clk(clk), .sys_rst(sysRst),
        .busModePinIn(pinLevel[0]), .busModePinOut(pinOut[0]), .busModePinOe(pinOe[0]),
        .polarityPinIn(pinLevel[1]), .polarityPinOut(pinOut[1]), .polarityPinOe(pinOe[1]),
        .gangPinIn(pinLevel[2]), .gangPinOut(pinOut[2]), .gangPinOe(pinOe[2]),
        .switchPinIn(pinLevel[3]), .switchPinOut(pinOut[3]), .switchPinOe(pinOe[3]),
        .testPinIn(testPin), .portSuperSpeed(portSs), .upstreamHighSpeed(upHs),
        .upstreamSuperSpeed(upSs), .portPowerRequest(pwrReq), .portChargeRequest(chgReq),
        .portOvercurrentInN(ocN), .serialClockIn(serClk), .portPowerControlOut(pwrOut),
        .chargingEnableOut(chgOut), .portOvercurrentEvent(ocEvt), .hubOvercurrentEvent(hubOc),
        .smbusTargetMode(smbMode), .i2cMasterMode(i2cMode), .smbusTargetClock(smbClk),
        .i2cMemoryClock(i2cClk), .targetAddress(addr), .gangedMode(ganged),
        .powerSwitchingOn(swOn), .factoryTestMode(testMode), .strapsValid(valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic close_out;
        $display("compared=%0d mismatches=%0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // reset with a strap set on the resistors, then let capture and run phase settle
    task automatic start(input logic [4:0] s);
        sysRst = 1'b1;
        strapVal = s[3:0];
        testPin = s[4];
        tick(3);
        chk({valid, pinOe}, {1'b0, {4{OE_RELEASE}}});
        sysRst = 1'b0;
        tick(8);
    endtask
    // the mode flags and the address follow the captured straps; the ganged flag is compared only when switching is strapped on
    task automatic check_modes;
        expAddr = ADDR_BASE;
        expAddr[ADDR_BIT3_POS] = ADDR_BIT3_VALUE;
        if (bm == BUS_MODE_SMBUS) begin
            expAddr[ADDR_BIT2_POS] = gang;
            expAddr[ADDR_BIT1_POS] = sw;
        end
        chk({smbMode, i2cMode}, {bm == BUS_MODE_SMBUS, bm});
        chk({swOn, testMode}, {sw == SWITCH_SUPPORTED, cfg[4]});
        if (sw == SWITCH_SUPPORTED) chk(ganged, gang);
        chk(addr, expAddr);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: each strap set is one reset, the next reset lands mid-run
    initial begin
        for (int c = 0; c < 5; c++) begin
            cfg = cfgTab[c];
            {sw, gang, pol, bm} = cfg[3:0];
            start(cfg);
            check_modes();
            chk({valid, pinOe}, {1'b1, {4{OE_DRIVE}}});
            for (int v = 0; v < 16; v++) begin
                {upSs, upHs, portSs} = v[3:0];
                tick(2);
                chk(pinLevel, {upSs, upHs, portSs[0], portSs[1]});
            end
            for (int v = 0; v < 16; v++) begin
                {chgReq, pwrReq} = v[3:0];
                tick(3);
                if (sw != SWITCH_SUPPORTED) expPwr = {2{pol}};
                else if (gang == GANG_GANGED) expPwr = {2{|pwrReq}} ^ {2{pol}};
                else expPwr = pwrReq ^ {2{pol}};
                chk(pwrOut, expPwr);
                if (sw == SWITCH_SUPPORTED && gang != GANG_GANGED) chk(chgOut, chgReq);
                else if (sw == SWITCH_SUPPORTED) chk(chgOut, {2{|chgReq}});
            end
            for (int v = 0; v < 4; v++) begin
                ocN = v[1:0];
                tick(5);
                // without switching the gang strap is ignored, so events stay per port
                if (gang != GANG_GANGED || sw != SWITCH_SUPPORTED) begin
                    chk({hubOc, ocEvt}, {1'b0, ~ocN});
                end else begin
                    chk({hubOc, ocEvt}, {~&ocN, 2'b00});
                end
            end
            serClk = 1'b1;
            tick(4);
            chk({smbClk, i2cClk}, {bm == BUS_MODE_SMBUS, bm});
            serClk = 1'b0;
            tick(4);
            chk({smbClk, i2cClk}, 2'b00);
            // later strap moves must not reach the captured state
            strapVal = ~strapVal;
            testPin = ~testPin;
            tick(6);
            check_modes();
        end
        close_out();
    end
endmodule
